/* hw/ffp_consts.vh */
// Constants for the flat-field and gain-map correction stage
`ifndef FFP_CONSTS_VH
`define FFP_CONSTS_VH
// Pixel and coordinate widths
`define FFP_PIX_W 12
`define FFP_COORD_W 8
// Scaled-down map: 3 x 3 nodes at columns/rows 0, 128, 255
`define FFP_NODES 9
`define FFP_NODE_ROW 4'h3
`define FFP_NODE_FIRST 8'h00
`define FFP_NODE_MID 8'h80
`define FFP_NODE_END 8'hFF
`define FFP_CELL_FULL 8'h80
`define FFP_NODE_NONE 2'h3
`define FFP_CENTRE_NODE 4'h4
// Non-volatile slots
`define FFP_FF_SLOTS 16
`define FFP_GM_SLOTS 4
`define FFP_GM_SLOT_DEFAULT 2'h0
// Reset and factory values
`define FFP_FF_RESET 12'h000
`define FFP_GM_RESET 12'h000
`define FFP_GM_FACTORY 12'h800
// Format limits and target source encoding
`define FFP_MAX8 12'h0FF
`define FFP_MAX12 12'hFFF
`define FFP_GOAL_USER 1'b1
// Buffer entry width: pixel, gain level, start of frame, end of line
`define FFP_BUF_W 26
`endif

/* hw/ffp_skid_buf.v */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module ffp_skid_buf (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [25:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [25:0] o_out_data
);
   reg [25:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;

   // Full at two entries, empty at zero
   assign o_in_ready = (count_reg != 2'h2);
   assign o_out_valid = (count_reg != 2'h0);
   assign o_out_data = mem_reg[rd_ptr_reg];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // Pointers and fill count
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         if (push & ~pop) count_reg <= count_reg + 2'h1;
         else if (pop & ~push) count_reg <= count_reg - 2'h1;
      end
   end

   // Entry storage, written only on push
   always @(posedge i_ref_clk) begin
      if (push) mem_reg[wr_ptr_reg] <= i_in_data;
   end
endmodule

/* hw/ffp_flat_field.v */
// Flat-field gain-uniformity correction stage with gain-map storage
`timescale 1ns/1ns
`include "ffp_consts.vh"
module ffp_flat_field (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_pix_valid,
   output wire o_pix_ready,
   input wire [11:0] i_pix_data,
   input wire i_pix_sof,
   input wire i_pix_eol,
   output wire o_pix_valid,
   input wire i_pix_ready,
   output wire [11:0] o_pix_data,
   output wire [11:0] o_gain_level,
   output wire o_pix_sof,
   output wire o_pix_eol,
   input wire i_fmt_8bit,
   input wire i_ff_apply_switch,
   input wire [3:0] i_ff_slot_pick,
   input wire i_ff_goal_source,
   input wire [11:0] i_ff_goal_value,
   input wire i_ff_build_cmd,
   input wire i_ff_store_cmd,
   input wire i_ff_restore_cmd,
   input wire [1:0] i_gain_map_slot_pick,
   input wire i_gain_map_build_cmd,
   input wire i_gain_map_store_cmd,
   input wire i_gain_map_restore_cmd,
   output reg o_ff_busy,
   output reg o_gain_map_busy,
   output reg o_gain_map_active,
   output reg o_cmd_refused,
   output reg [11:0] o_goal_level
);
   // Capture state machine, one-hot
   localparam ST_IDLE = 3'b001;
   localparam ST_ARMED = 3'b010;
   localparam ST_CAPTURE = 3'b100;

   reg [2:0] state_reg;
   reg gm_target_reg;
   reg [7:0] x_reg;
   reg [7:0] y_reg;
   reg [11:0] ff_act_reg [0:8];
   reg [11:0] gm_act_reg [0:8];
   reg [11:0] ff_slot_reg [0:143];
   reg [11:0] gm_slot_reg [0:35];
   wire accept;
   wire [7:0] cur_x;
   wire [7:0] cur_y;
   wire [1:0] node_c;
   wire [1:0] node_r;
   wire [3:0] node_n;
   wire last_pix;
   wire [11:0] max_code;
   integer k_fa;
   integer k_fs;
   integer k_ga;
   integer k_gs;

   // Node index of a coordinate, or none when it is not on the grid
   function [1:0] ffp_node_of;
      input [7:0] c;
      begin
         if (c == `FFP_NODE_FIRST) ffp_node_of = 2'h0;
         else if (c == `FFP_NODE_MID) ffp_node_of = 2'h1;
         else if (c == `FFP_NODE_END) ffp_node_of = 2'h2;
         else ffp_node_of = `FFP_NODE_NONE;
      end
   endfunction

   // Flat index of a map node from its row and column
   function [3:0] ffp_idx;
      input [1:0] r;
      input [1:0] c;
      reg [5:0] p;
      begin
         p = {2'h0, r} * {2'h0, `FFP_NODE_ROW};
         ffp_idx = p[3:0] + {2'h0, c};
      end
   endfunction

   // Linear blend of two node levels, weight f out of 128
   function [11:0] ffp_lerp;
      input [11:0] a;
      input [11:0] b;
      input [6:0] f;
      reg [19:0] s;
      begin
         s = ({8'h00, a} * {12'h000, `FFP_CELL_FULL - {1'b0, f}})
            + ({8'h00, b} * {13'h0000, f});
         ffp_lerp = s[18:7];
      end
   endfunction

   // Pixel position within the frame
   assign accept = i_pix_valid & o_pix_ready;
   assign cur_x = i_pix_sof ? 8'h00 : x_reg;
   assign cur_y = i_pix_sof ? 8'h00 : y_reg;
   assign node_c = ffp_node_of(cur_x);
   assign node_r = ffp_node_of(cur_y);
   assign node_n = ffp_idx(node_r, node_c);
   assign last_pix = i_pix_eol & (cur_y == `FFP_NODE_END);
   assign max_code = i_fmt_8bit ? `FFP_MAX8 : `FFP_MAX12;

   // Coordinate counters follow start of frame and end of line
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         x_reg <= 8'h00;
         y_reg <= 8'h00;
      end else if (accept) begin
         if (i_pix_eol) begin
            x_reg <= 8'h00;
            y_reg <= cur_y + 8'h01;
         end else begin
            x_reg <= cur_x + 8'h01;
            y_reg <= cur_y;
         end
      end
   end

   // Bilinear enlargement of the active flat-field map
   wire [1:0] cell_c = {1'b0, cur_x[7]};
   wire [1:0] cell_r = {1'b0, cur_y[7]};
   wire [11:0] n00 = ff_act_reg[ffp_idx(cell_r, cell_c)];
   wire [11:0] n01 = ff_act_reg[ffp_idx(cell_r, cell_c + 2'h1)];
   wire [11:0] n10 = ff_act_reg[ffp_idx(cell_r + 2'h1, cell_c)];
   wire [11:0] n11 = ff_act_reg[ffp_idx(cell_r + 2'h1, cell_c + 2'h1)];
   wire [11:0] row_top = ffp_lerp(n00, n01, cur_x[6:0]);
   wire [11:0] row_bot = ffp_lerp(n10, n11, cur_x[6:0]);
   wire [11:0] ff_level = ffp_lerp(row_top, row_bot, cur_y[6:0]);

   // Target level: centre of map in auto, programmed value otherwise
   reg [11:0] goal_raw;
   reg [11:0] goal_eff;
   always @* begin
      goal_raw = ff_act_reg[`FFP_CENTRE_NODE];
      if (i_ff_goal_source == `FFP_GOAL_USER) goal_raw = i_ff_goal_value;
      goal_eff = goal_raw;
      if (goal_raw == 12'h000) goal_eff = 12'h001;
      else if (goal_raw > max_code) goal_eff = max_code;
   end

   // Division path: level times target over interpolated flat-field level
   reg [11:0] pix_in;
   reg [23:0] num;
   reg [23:0] quot;
   reg [11:0] pix_out;
   always @* begin
      pix_in = i_fmt_8bit ? {4'h0, i_pix_data[7:0]} : i_pix_data;
      num = {12'h000, pix_in} * {12'h000, goal_eff};
      quot = {12'h000, pix_in};
      if (ff_level != 12'h000) quot = num / {12'h000, ff_level};
      pix_out = pix_in;
      if (i_ff_apply_switch) begin
         if (quot > {12'h000, max_code}) pix_out = max_code;
         else pix_out = quot[11:0];
      end
   end

   // Nearest gain-map node travels beside each pixel
   wire [1:0] near_c = cur_x[7] ? (cur_x[6] ? 2'h2 : 2'h1) : (cur_x[6] ? 2'h1 : 2'h0);
   wire [1:0] near_r = cur_y[7] ? (cur_y[6] ? 2'h2 : 2'h1) : (cur_y[6] ? 2'h1 : 2'h0);
   wire [11:0] gain_near = o_gain_map_active ? gm_act_reg[ffp_idx(near_r, near_c)] : 12'h000;

   // Output buffer absorbs a stall by the receiver
   wire [25:0] buf_out;
   ffp_skid_buf u_buf (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_in_valid(i_pix_valid),
      .o_in_ready(o_pix_ready),
      .i_in_data({i_pix_sof, i_pix_eol, gain_near, pix_out}),
      .o_out_valid(o_pix_valid),
      .i_out_ready(i_pix_ready),
      .o_out_data(buf_out)
   );
   assign o_pix_data = buf_out[11:0];
   assign o_gain_level = buf_out[23:12];
   assign o_pix_eol = buf_out[24];
   assign o_pix_sof = buf_out[25];

   // Commands that may be taken this cycle
   wire build_any = i_ff_build_cmd | i_gain_map_build_cmd;
   wire gm_store_ok = i_gain_map_store_cmd & (i_gain_map_slot_pick != `FFP_GM_SLOT_DEFAULT);
   wire node_hit = accept & ((state_reg == ST_CAPTURE) | ((state_reg == ST_ARMED) & i_pix_sof))
      & (node_c != `FFP_NODE_NONE) & (node_r != `FFP_NODE_NONE);

   // Capture sequencing: arm on build, take the next whole frame
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
         gm_target_reg <= 1'b0;
         o_ff_busy <= 1'b0;
         o_gain_map_busy <= 1'b0;
         o_cmd_refused <= 1'b0;
      end else begin
         o_cmd_refused <= (build_any & (state_reg != ST_IDLE))
            | (i_gain_map_store_cmd & ~gm_store_ok);
         case (state_reg)
            ST_IDLE: begin
               if (build_any) begin
                  state_reg <= ST_ARMED;
                  gm_target_reg <= ~i_ff_build_cmd;
                  o_ff_busy <= i_ff_build_cmd;
                  o_gain_map_busy <= ~i_ff_build_cmd;
               end
            end
            ST_ARMED: begin
               if (accept & i_pix_sof) state_reg <= ST_CAPTURE;
            end
            ST_CAPTURE: begin
               if (accept & last_pix) begin
                  state_reg <= ST_IDLE;
                  o_ff_busy <= 1'b0;
                  o_gain_map_busy <= 1'b0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // A restore of the map being built cancels that build
         if ((i_ff_restore_cmd & ~gm_target_reg) | (i_gain_map_restore_cmd & gm_target_reg))
         begin
            if (state_reg != ST_IDLE) begin
               state_reg <= ST_IDLE;
               o_ff_busy <= 1'b0;
               o_gain_map_busy <= 1'b0;
            end
         end
      end
   end

   // Active flat-field map: volatile, cleared by reset
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (k_fa = 0; k_fa < `FFP_NODES; k_fa = k_fa + 1) ff_act_reg[k_fa] <= `FFP_FF_RESET;
      end else if (i_ff_restore_cmd) begin
         for (k_fa = 0; k_fa < `FFP_NODES; k_fa = k_fa + 1)
            ff_act_reg[k_fa] <= ff_slot_reg[{i_ff_slot_pick, 4'h0} - {i_ff_slot_pick, 3'h0}
               + {i_ff_slot_pick, 1'b0} - {4'h0, i_ff_slot_pick} + k_fa[7:0]];
      end else if (node_hit & ~gm_target_reg) begin
         ff_act_reg[node_n] <= pix_in;
      end
   end

   // Flat-field slots keep their contents through reset
   always @(posedge i_ref_clk) begin
      if (i_ff_store_cmd) begin
         for (k_fs = 0; k_fs < `FFP_NODES; k_fs = k_fs + 1)
            ff_slot_reg[{i_ff_slot_pick, 4'h0} - {i_ff_slot_pick, 3'h0}
               + {i_ff_slot_pick, 1'b0} - {4'h0, i_ff_slot_pick} + k_fs[7:0]]
               <= ff_act_reg[k_fs];
      end
   end

   // Active gain map: volatile, activated by a build or a restore
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_gain_map_active <= 1'b0;
         for (k_ga = 0; k_ga < `FFP_NODES; k_ga = k_ga + 1) gm_act_reg[k_ga] <= `FFP_GM_RESET;
      end else if (i_gain_map_restore_cmd) begin
         o_gain_map_active <= 1'b1;
         for (k_ga = 0; k_ga < `FFP_NODES; k_ga = k_ga + 1) begin
            if (i_gain_map_slot_pick == `FFP_GM_SLOT_DEFAULT)
               gm_act_reg[k_ga] <= `FFP_GM_FACTORY;
            else
               gm_act_reg[k_ga] <= gm_slot_reg[{i_gain_map_slot_pick, 3'h0}
                  + {3'h0, i_gain_map_slot_pick} + k_ga[5:0]];
         end
      end else if (node_hit & gm_target_reg) begin
         o_gain_map_active <= 1'b1;
         gm_act_reg[node_n] <= pix_in;
      end
   end

   // User gain-map slots; the default slot is never written
   always @(posedge i_ref_clk) begin
      if (gm_store_ok) begin
         for (k_gs = 0; k_gs < `FFP_NODES; k_gs = k_gs + 1)
            gm_slot_reg[{i_gain_map_slot_pick, 3'h0} + {3'h0, i_gain_map_slot_pick}
               + k_gs[5:0]] <= gm_act_reg[k_gs];
      end
   end

   // Effective target level shown to the host
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) o_goal_level <= 12'h000;
      else o_goal_level <= goal_eff;
   end
endmodule

/* verif/ffp_sensor_model.sv */
// Pixel source model standing in for the image sensor
`timescale 1ns/1ns
module ffp_sensor_model (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_go,
   input wire [16:0] i_count,
   input wire [11:0] i_level,
   input wire i_ready,
   output wire o_valid,
   output wire [11:0] o_data,
   output wire o_sof,
   output wire o_eol
);
   reg [16:0] left_reg;
   reg [15:0] pos_reg;
   // Word held until ready is seen; released data shows the inverse level
   assign o_valid = (left_reg != 17'h00000);
   assign o_data = o_valid ? i_level : ~i_level;
   assign o_sof = o_valid && (pos_reg == 16'h0000);
   assign o_eol = o_valid && (pos_reg[7:0] == 8'hFF);
   // Whole frame of 256 x 256 at one level gives uniform light
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         left_reg <= 17'h00000;
         pos_reg <= 16'h0000;
      end else if (i_go) begin
         left_reg <= i_count;
         pos_reg <= 16'h0000;
      end else if (o_valid && i_ready) begin
         left_reg <= left_reg - 17'h00001;
         pos_reg <= pos_reg + 16'h0001;
      end
   end
endmodule

/* verif/ffp_flat_field_assertions.sv */
// Port checker for the flat-field correction stage
`timescale 1ns/1ns
module ffp_flat_field_assertions (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_pix_valid,
   input wire o_pix_ready,
   input wire [11:0] i_pix_data,
   input wire o_pix_valid,
   input wire i_pix_ready,
   input wire [11:0] o_pix_data,
   input wire [11:0] o_gain_level,
   input wire i_fmt_8bit,
   input wire i_ff_apply_switch,
   input wire i_ff_goal_source,
   input wire [11:0] i_ff_goal_value,
   input wire i_ff_build_cmd,
   input wire i_ff_restore_cmd,
   input wire [1:0] i_gain_map_slot_pick,
   input wire i_gain_map_build_cmd,
   input wire i_gain_map_store_cmd,
   input wire i_gain_map_restore_cmd,
   input wire o_ff_busy,
   input wire o_gain_map_busy,
   input wire o_gain_map_active,
   input wire o_cmd_refused,
   input wire [11:0] o_goal_level
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   a_pass_when_off: assert property (!o_pix_valid && i_pix_valid && o_pix_ready
      && !i_fmt_8bit && !i_ff_apply_switch |=> o_pix_valid && o_pix_data == $past(i_pix_data))
      else $error("pixel not passed unchanged");
   a_build_sets_busy: assert property (i_ff_build_cmd && !o_ff_busy && !o_gain_map_busy
      && !i_ff_restore_cmd |=> o_ff_busy) else $error("build did not raise busy");
   a_build_refused: assert property (i_ff_build_cmd && o_ff_busy |=> o_cmd_refused)
      else $error("second build not refused");
   a_restore_cancels: assert property (o_ff_busy && i_ff_restore_cmd
      && !i_ff_build_cmd |=> !o_ff_busy) else $error("restore left build running");
   a_gain_cancel: assert property (o_gain_map_busy && i_gain_map_restore_cmd
      && !i_gain_map_build_cmd |=> !o_gain_map_busy) else $error("gain build kept");
   a_default_store: assert property (i_gain_map_store_cmd
      && i_gain_map_slot_pick == 2'h0 |=> o_cmd_refused)
      else $error("store to default slot accepted");
   a_refuse_cause: assert property (o_cmd_refused |-> $past(i_ff_build_cmd
      || i_gain_map_build_cmd || i_gain_map_store_cmd)) else $error("refusal without cause");
   a_gain_restore: assert property (i_gain_map_restore_cmd |=> o_gain_map_active)
      else $error("gain map not active after restore");
   a_gain_idle: assert property (!o_gain_map_active && o_pix_valid
      |-> o_gain_level == 12'h000) else $error("gain level shown while inactive");
   a_goal_user: assert property (i_ff_goal_source && !i_fmt_8bit
      && i_ff_goal_value != 12'h000 |=> o_goal_level == $past(i_ff_goal_value))
      else $error("user goal not used");
   a_goal_clamp: assert property (i_ff_goal_source && i_fmt_8bit
      && i_ff_goal_value > 12'h0FF |=> o_goal_level == 12'h0FF)
      else $error("8-bit goal not clamped");
   a_hold_stall: assert property (o_pix_valid && !i_pix_ready
      |=> o_pix_valid && $stable(o_pix_data)) else $error("stalled word lost");
endmodule
bind ffp_flat_field ffp_flat_field_assertions u_chk (.i_ref_clk, .i_rstn, .i_pix_valid,
   .o_pix_ready, .i_pix_data, .o_pix_valid, .i_pix_ready, .o_pix_data, .o_gain_level,
   .i_fmt_8bit, .i_ff_apply_switch, .i_ff_goal_source, .i_ff_goal_value, .i_ff_build_cmd,
   .i_ff_restore_cmd, .i_gain_map_slot_pick, .i_gain_map_build_cmd, .i_gain_map_store_cmd,
   .i_gain_map_restore_cmd, .o_ff_busy, .o_gain_map_busy, .o_gain_map_active,
   .o_cmd_refused, .o_goal_level);

/* verif/tb_top.sv */
// Testbench for the flat-field correction stage
`timescale 1ns/1ns
module tb_top;
   reg i_ref_clk = 0, i_rstn = 0, i_pix_ready = 1, i_fmt_8bit = 0, apply = 0, src = 0, go = 0;
   reg [3:0] ff_slot = 0;
   reg [1:0] gm_slot = 0;
   reg [5:0] cmd = 0;
   reg [11:0] goal = 0, lvl = 0;
   reg [16:0] cnt = 1;
   wire m_valid, m_sof, m_eol, o_pix_ready, o_pix_valid, o_ff_busy, o_gain_map_busy;
   wire o_gain_map_active, o_cmd_refused;
   wire o_pix_sof, o_pix_eol;
   wire [11:0] m_data, o_pix_data, o_gain_level, o_goal_level;
   integer err_count = 0, n_tests = 0, k;
   // Clock of 10 ns
   always #5 i_ref_clk = ~i_ref_clk;
   ffp_sensor_model u_src (.i_ref_clk, .i_rstn, .i_go(go), .i_count(cnt), .i_level(lvl),
      .i_ready(o_pix_ready), .o_valid(m_valid), .o_data(m_data), .o_sof(m_sof), .o_eol(m_eol));
   ffp_flat_field u_dut (.i_ref_clk, .i_rstn, .i_pix_valid(m_valid), .o_pix_ready,
      .i_pix_data(m_data), .i_pix_sof(m_sof), .i_pix_eol(m_eol), .o_pix_valid, .i_pix_ready,
      .o_pix_data, .o_gain_level, .o_pix_sof, .o_pix_eol, .i_fmt_8bit,
      .i_ff_apply_switch(apply), .i_ff_slot_pick(ff_slot), .i_ff_goal_source(src),
      .i_ff_goal_value(goal), .i_ff_build_cmd(cmd[0]), .i_ff_store_cmd(cmd[1]),
      .i_ff_restore_cmd(cmd[2]), .i_gain_map_slot_pick(gm_slot),
      .i_gain_map_build_cmd(cmd[3]), .i_gain_map_store_cmd(cmd[4]),
      .i_gain_map_restore_cmd(cmd[5]), .o_ff_busy, .o_gain_map_busy, .o_gain_map_active,
      .o_cmd_refused, .o_goal_level);
   task check(input [63:0] name, input [11:0] seen, input [11:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // One-cycle command pulse with slot selectors, then settle
   task pulse(input integer i, input [3:0] fs, input [1:0] gs);
      begin
         @(posedge i_ref_clk) begin
            cmd[i] <= 1'b1;
            ff_slot <= fs;
            gm_slot <= gs;
         end
         @(posedge i_ref_clk) cmd <= 6'h00;
         @(negedge i_ref_clk);
      end
   endtask
   task stream(input [16:0] n, input [11:0] l);
      begin
         @(posedge i_ref_clk) begin
            go <= 1'b1;
            cnt <= n;
            lvl <= l;
         end
         @(posedge i_ref_clk) go <= 1'b0;
      end
   endtask
   // Single pixel at the frame origin, output word compared
   task pix(input [11:0] l, input [11:0] ed, input [11:0] eg);
      begin
         stream(17'h00001, l);
         k = 0;
         @(negedge i_ref_clk);
         while (o_pix_valid !== 1'b1 && k < 20) begin
            @(negedge i_ref_clk);
            k = k + 1;
         end
         check("pix_data", o_pix_data, ed);
         check("gain", o_gain_level, eg);
         check("sof_eol", {10'h000, o_pix_sof, o_pix_eol}, 12'h002);
      end
   endtask
   task end_of_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   // Watchdog: about 90,000 cycles, well past one full frame plus the short tests
   initial begin
      #900000;
      err_count = err_count + 1;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      repeat (2) @(negedge i_ref_clk);
      check("idle", {9'h000, o_pix_ready, o_pix_valid, o_ff_busy}, 12'h004);
      check("goal", o_goal_level, 12'h001);
      pulse(1, 4'h2, 2'h0);
      pix(12'h123, 12'h123, 12'h000);
      @(posedge i_ref_clk) apply <= 1'b1;
      pix(12'h0AB, 12'h0AB, 12'h000);
      // Fill the buffer with the sink stalled, then drain it
      @(posedge i_ref_clk) begin
         apply <= 1'b0;
         i_pix_ready <= 1'b0;
      end
      stream(17'h00003, 12'h007);
      repeat (5) @(negedge i_ref_clk);
      check("full", {11'h000, o_pix_ready}, 12'h000);
      @(posedge i_ref_clk) i_pix_ready <= 1'b1;
      k = 0;
      repeat (6) begin
         @(negedge i_ref_clk);
         if (o_pix_valid === 1'b1) k = k + 1;
      end
      check("words", k[11:0], 12'h003);
      pulse(0, 4'h2, 2'h0);
      check("busy", {11'h000, o_ff_busy}, 12'h001);
      pulse(0, 4'h2, 2'h0);
      check("refused", {11'h000, o_cmd_refused}, 12'h001);
      stream(17'h10000, 12'h064);
      k = 0;
      while (o_ff_busy !== 1'b0 && k < 70000) begin
         @(negedge i_ref_clk);
         k = k + 1;
      end
      check("busy_end", {11'h000, o_ff_busy}, 12'h000);
      check("goal", o_goal_level, 12'h064);
      pulse(1, 4'h5, 2'h0);
      @(posedge i_ref_clk) begin
         src <= 1'b1;
         goal <= 12'h190;
         apply <= 1'b1;
      end
      pix(12'h032, 12'h0C8, 12'h000);
      pix(12'hFA0, 12'hFFF, 12'h000);
      @(posedge i_ref_clk) i_fmt_8bit <= 1'b1;
      repeat (2) @(negedge i_ref_clk);
      check("goal8", o_goal_level, 12'h0FF);
      pix(12'h014, 12'h033, 12'h000);
      @(posedge i_ref_clk) begin
         i_fmt_8bit <= 1'b0;
         src <= 1'b0;
      end
      pulse(2, 4'h2, 2'h0);
      @(negedge i_ref_clk);
      check("goal", o_goal_level, 12'h001);
      pix(12'h032, 12'h032, 12'h000);
      pulse(2, 4'h5, 2'h0);
      @(negedge i_ref_clk);
      check("goal", o_goal_level, 12'h064);
      pulse(5, 4'h5, 2'h0);
      check("active", {11'h000, o_gain_map_active}, 12'h001);
      pix(12'h032, 12'h032, 12'h800);
      pulse(4, 4'h5, 2'h0);
      check("refused", {11'h000, o_cmd_refused}, 12'h001);
      pulse(4, 4'h5, 2'h1);
      pulse(5, 4'h5, 2'h1);
      pix(12'h032, 12'h032, 12'h800);
      @(posedge i_ref_clk) apply <= 1'b0;
      pulse(3, 4'h5, 2'h1);
      check("gm_busy", {11'h000, o_gain_map_busy}, 12'h001);
      // Origin pixel of the free-run frame lands in the gain map at once
      pix(12'h0A0, 12'h0A0, 12'h800);
      pix(12'h0B4, 12'h0B4, 12'h0A0);
      pulse(5, 4'h5, 2'h1);
      check("gm_busy", {11'h000, o_gain_map_busy}, 12'h000);
      pix(12'h032, 12'h032, 12'h800);
      pulse(0, 4'h5, 2'h1);
      pulse(2, 4'h5, 2'h1);
      check("cancel", {11'h000, o_ff_busy}, 12'h000);
      // Mid-run reset loses the active maps but keeps the slots
      @(posedge i_ref_clk) i_rstn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      repeat (2) @(negedge i_ref_clk);
      check("goal_rst", o_goal_level, 12'h001);
      check("act_rst", {11'h000, o_gain_map_active}, 12'h000);
      pulse(2, 4'h5, 2'h0);
      @(negedge i_ref_clk);
      check("goal_nv", o_goal_level, 12'h064);
      end_of_test;
   end
endmodule
